// File: crossbar_pkg.sv
// Purpose: shared constants for the port crossbar and pin setup block
// Assumes: 24 port pins (three ports of eight), 23 crossbar signals
// Notes:   byte offsets on a 32-bit classic Wishbone bus
package crossbar_pkg;
  localparam int PIN_CNT = 24;
  localparam int SIG_CNT = 23;
  localparam int PIN_W   = 5;
  localparam int SIG_W   = 5;

  // register byte offsets
  localparam logic [7:0] ADR_ROUTE_FIRST  = 8'h00;
  localparam logic [7:0] ADR_ROUTE_SECOND = 8'h04;
  localparam logic [7:0] ADR_ROUTE_THIRD  = 8'h08;
  localparam logic [7:0] ADR_PIN_SKIP     = 8'h0c;
  localparam logic [7:0] ADR_INPUT_MODE   = 8'h10;
  localparam logic [7:0] ADR_OUTPUT_MODE  = 8'h14;
  localparam logic [7:0] ADR_PORT_LATCH   = 8'h18;
  localparam logic [7:0] ADR_PIN_LEVEL    = 8'h1c;
  localparam logic [7:0] ADR_SPI_CONFIG   = 8'h20;
  localparam logic [7:0] ADR_ASSIGNED     = 8'h24;

  // field positions
  localparam int F0_UART0  = 0;
  localparam int F0_SPI    = 1;
  localparam int F0_SMBUS  = 2;
  localparam int F0_SYSCLK = 3;
  localparam int F0_CMP0   = 4;
  localparam int F0_CMP0A  = 5;
  localparam int F0_CMP1   = 6;
  localparam int F0_CMP1A  = 7;
  localparam int F1_PCA_LO = 0;
  localparam int F1_ECI    = 3;
  localparam int F1_TMR0   = 4;
  localparam int F1_TMR1   = 5;
  localparam int F1_XBAR   = 6;
  localparam int F1_WPUD   = 7;
  localparam int F2_UART1  = 0;
  localparam logic [2:0] PCA_MAX = 3'h5;

  // reset values
  localparam logic [23:0] RST_INPUT_MODE  = 24'hffffff;
  localparam logic [23:0] RST_OUTPUT_MODE = 24'h000000;
  localparam logic [23:0] RST_PORT_LATCH  = 24'hffffff;

  // crossbar signals in priority order
  localparam int SIG_UART0_TRANSMIT = 0;
  localparam int SIG_UART0_RECEIVE  = 1;
  localparam int SIG_SPI_CLOCK      = 2;
  localparam int SIG_SPI_MISO       = 3;
  localparam int SIG_SPI_MOSI       = 4;
  localparam int SIG_SPI_SLAVE_SEL  = 5;
  localparam int SIG_SMBUS_DATA     = 6;
  localparam int SIG_SMBUS_CLOCK    = 7;
  localparam int SIG_CMP_ZERO_OUT   = 8;
  localparam int SIG_CMP_ZERO_ASYNC = 9;
  localparam int SIG_CMP_ONE_OUT    = 10;
  localparam int SIG_CMP_ONE_ASYNC  = 11;
  localparam int SIG_SYSCLK_OUT     = 12;
  localparam int SIG_PCA_CH0        = 13;
  localparam int SIG_PCA_COUNT_IN   = 18;
  localparam int SIG_TIMER_ZERO     = 19;
  localparam int SIG_TIMER_ONE      = 20;
  localparam int SIG_UART1_TRANSMIT = 21;
  localparam int SIG_UART1_RECEIVE  = 22;

  // fixed pins of the first uart
  localparam logic [PIN_W-1:0] UART0_TX_PIN = 5'h04;
  localparam logic [PIN_W-1:0] UART0_RX_PIN = 5'h05;
endpackage

// File: pad_model.sv
// Purpose: external pads seen by the crossbar
// Assumes: pullup gives 1, undriven unpulled pad wanders
// Notes:   driver wins over the external source
`timescale 1ns/10ps
`default_nettype none
module pad_model (
  input  wire logic        clk_i,
  input  wire logic [23:0] pin_out_i,
  input  wire logic [23:0] pin_oe_i,
  input  wire logic [23:0] pin_pullup_i,
  input  wire logic [23:0] ext_en_i,
  input  wire logic [23:0] ext_lvl_i,
  output var  logic [23:0] pad_o
);
  logic toggle_q = 1'b0;
  // floating level changes every cycle
  always_ff @(posedge clk_i) begin
    toggle_q <= ~toggle_q;
  end
  // pad level from all drivers
  always_comb begin
    pad_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_en_i & ext_lvl_i)
          | (~pin_oe_i & ~ext_en_i & (pin_pullup_i | {24{toggle_q}}));
  end
endmodule
`default_nettype wire

// File: port_crossbar.sv
// Contract
// - enabled signals receive pins in one fixed priority order
// - pins with skip bit 1 are never handed to a crossbar signal other than the first uart
// - oscillator and reference pins are not routed; software skips them
// - spi slave select takes a pin only in four-wire mode
// - analog pins lose pullup, output driver and input receiver
// - input mode bit 1 means digital, 0 means analog
// - all pins are digital inputs after reset
// - output mode bit picks open-drain or push-pull, peripherals too, except the smbus data and clock pins
// - smbus data and clock pins are always open-drain
// - weak pullup on open-drain pins while pullup disable is 0
// - weak pullup is off while the pin drives a logic 0
// - crossbar enable 1 routes selected signals to pins
// - crossbar off makes every pin an ordinary port input
// - crossbar off holds every output driver disabled
// - smbus and uart pins are assigned as a pair or not at all
// - first uart transmit and receive sit on port 0 pins 4 and 5
// - untaken pins stay standard port i/o
//
// Purpose: priority crossbar with pin mode, pullup and skip control
// Assumes: classic Wishbone slave, one clock, synchronous reset
// Notes:   every output is registered, so pins follow one cycle late
`timescale 1ns/10ps
`default_nettype none
module port_crossbar #(
  parameter int PIN_COUNT = crossbar_pkg::PIN_CNT
) (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              ce_i,
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [7:0]                        wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [31:0]                       wb_dat_i,
  output var  logic [31:0]                       wb_dat_o,
  output var  logic                              wb_ack_o,
  input  wire logic [crossbar_pkg::PIN_CNT-1:0]  pin_in_i,
  output var  logic [crossbar_pkg::PIN_CNT-1:0]  pin_out_o,
  output var  logic [crossbar_pkg::PIN_CNT-1:0]  pin_oe_o,
  output var  logic [crossbar_pkg::PIN_CNT-1:0]  pin_pullup_o,
  output var  logic [crossbar_pkg::PIN_CNT-1:0]  pin_rx_en_o,
  input  wire logic [crossbar_pkg::SIG_CNT-1:0]  periph_out_i,
  input  wire logic [crossbar_pkg::SIG_CNT-1:0]  periph_oe_i,
  output var  logic [crossbar_pkg::SIG_CNT-1:0]  periph_in_o
);
  import crossbar_pkg::*;

  // refuse pin counts the fixed register layout cannot hold
  if (PIN_COUNT != PIN_CNT) begin : g_pin_check
    $error("port_crossbar supports exactly 24 pins");
  end

  typedef struct packed {
    logic [7:0]         route_first;
    logic [7:0]         route_second;
    logic [1:0]         route_third;
    logic [PIN_CNT-1:0] pin_skip_mask;
    logic [PIN_CNT-1:0] input_mode_select;
    logic [PIN_CNT-1:0] output_mode_select;
    logic [PIN_CNT-1:0] port_latch;
    logic               spi_four_wire;
    logic [PIN_CNT-1:0] sync_first;
    logic [PIN_CNT-1:0] sync_second;
    logic               ack;
    logic [31:0]        rdata;
    logic [PIN_CNT-1:0] pin_out;
    logic [PIN_CNT-1:0] pin_oe;
    logic [PIN_CNT-1:0] pin_pullup;
    logic [PIN_CNT-1:0] pin_rx_en;
    logic [SIG_CNT-1:0] periph_in;
    logic [PIN_CNT-1:0] assigned;
  } state_t;

  state_t q;
  state_t d;

  logic [SIG_CNT-1:0] sig_en;
  logic [SIG_CNT-1:0] sig_on;
  logic [PIN_W-1:0]   sig_pin [SIG_CNT];
  logic [SIG_W-1:0]   pin_owner [PIN_CNT];
  logic [PIN_CNT-1:0] used;
  logic [PIN_CNT-1:0] owned;
  logic [PIN_W:0]     free_a;
  logic [PIN_W:0]     free_b;
  logic [31:0]        rd;
  logic [31:0]        wm;
  logic               wr_now;
  logic               crossbar_on;

  // lowest pin not yet taken, valid flag on top
  function automatic logic [PIN_W:0] first_free(input logic [PIN_CNT-1:0] taken);
    logic [PIN_W:0] r;
    r = '0;
    for (int p = PIN_CNT - 1; p >= 0; p--) begin
      if (!taken[p]) begin
        r = {1'b1, PIN_W'(p)};
      end
    end
    return r;
  endfunction

  // byte-lane write merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // bus, registers, allocation and pin drive
  always_comb begin
    d = q;
    crossbar_on = q.route_second[F1_XBAR];
    // pin levels pass two flip-flops first
    d.sync_first  = pin_in_i;
    d.sync_second = q.sync_first;

    // signal enables from route selections
    sig_en = '0;
    sig_en[SIG_UART0_TRANSMIT] = q.route_first[F0_UART0];
    sig_en[SIG_UART0_RECEIVE]  = q.route_first[F0_UART0];
    sig_en[SIG_SPI_CLOCK]      = q.route_first[F0_SPI];
    sig_en[SIG_SPI_MISO]       = q.route_first[F0_SPI];
    sig_en[SIG_SPI_MOSI]       = q.route_first[F0_SPI];
    sig_en[SIG_SPI_SLAVE_SEL]  = q.route_first[F0_SPI] & q.spi_four_wire;
    sig_en[SIG_SMBUS_DATA]     = q.route_first[F0_SMBUS];
    sig_en[SIG_SMBUS_CLOCK]    = q.route_first[F0_SMBUS];
    sig_en[SIG_CMP_ZERO_OUT]   = q.route_first[F0_CMP0];
    sig_en[SIG_CMP_ZERO_ASYNC] = q.route_first[F0_CMP0A];
    sig_en[SIG_CMP_ONE_OUT]    = q.route_first[F0_CMP1];
    sig_en[SIG_CMP_ONE_ASYNC]  = q.route_first[F0_CMP1A];
    sig_en[SIG_SYSCLK_OUT]     = q.route_first[F0_SYSCLK];
    for (int k = 0; k < 5; k++) begin
      // reserved counts route no pca channel
      sig_en[SIG_PCA_CH0 + k] = (q.route_second[F1_PCA_LO +: 3] <= PCA_MAX)
                                && (q.route_second[F1_PCA_LO +: 3] > 3'(k));
    end
    sig_en[SIG_PCA_COUNT_IN]   = q.route_second[F1_ECI];
    sig_en[SIG_TIMER_ZERO]     = q.route_second[F1_TMR0];
    sig_en[SIG_TIMER_ONE]      = q.route_second[F1_TMR1];
    sig_en[SIG_UART1_TRANSMIT] = q.route_third[F2_UART1];
    sig_en[SIG_UART1_RECEIVE]  = q.route_third[F2_UART1];

    // allocation scan in priority order
    used   = q.pin_skip_mask;
    owned  = '0;
    sig_on = '0;
    free_a = '0;
    free_b = '0;
    for (int s = 0; s < SIG_CNT; s++) begin
      sig_pin[s] = '0;
    end
    for (int p = 0; p < PIN_CNT; p++) begin
      pin_owner[p] = '0;
    end
    if (sig_en[SIG_UART0_TRANSMIT]) begin
      // first uart is pinned regardless of skip and priority
      sig_on[SIG_UART0_TRANSMIT]  = 1'b1;
      sig_on[SIG_UART0_RECEIVE]   = 1'b1;
      sig_pin[SIG_UART0_TRANSMIT] = UART0_TX_PIN;
      sig_pin[SIG_UART0_RECEIVE]  = UART0_RX_PIN;
      used[UART0_TX_PIN]  = 1'b1;
      used[UART0_RX_PIN]  = 1'b1;
      owned[UART0_TX_PIN] = 1'b1;
      owned[UART0_RX_PIN] = 1'b1;
      pin_owner[UART0_TX_PIN] = SIG_W'(SIG_UART0_TRANSMIT);
      pin_owner[UART0_RX_PIN] = SIG_W'(SIG_UART0_RECEIVE);
    end
    for (int s = SIG_SPI_CLOCK; s < SIG_CNT; s++) begin
      if (sig_en[s] && s != SIG_SMBUS_CLOCK && s != SIG_UART1_RECEIVE) begin
        free_a = first_free(used);
        if (s == SIG_SMBUS_DATA || s == SIG_UART1_TRANSMIT) begin
          // pair partner needs a second free pin or neither is routed
          free_b = first_free(used | (PIN_CNT'(1) << free_a[PIN_W-1:0]));
          if (free_a[PIN_W] && free_b[PIN_W]) begin
            sig_on[s]     = 1'b1;
            sig_on[s + 1] = 1'b1;
            sig_pin[s]     = free_a[PIN_W-1:0];
            sig_pin[s + 1] = free_b[PIN_W-1:0];
            used[free_a[PIN_W-1:0]]  = 1'b1;
            used[free_b[PIN_W-1:0]]  = 1'b1;
            owned[free_a[PIN_W-1:0]] = 1'b1;
            owned[free_b[PIN_W-1:0]] = 1'b1;
            pin_owner[free_a[PIN_W-1:0]] = SIG_W'(s);
            pin_owner[free_b[PIN_W-1:0]] = SIG_W'(s + 1);
          end
        end else if (free_a[PIN_W]) begin
          sig_on[s]  = 1'b1;
          sig_pin[s] = free_a[PIN_W-1:0];
          used[free_a[PIN_W-1:0]]  = 1'b1;
          owned[free_a[PIN_W-1:0]] = 1'b1;
          pin_owner[free_a[PIN_W-1:0]] = SIG_W'(s);
        end
      end
    end
    d.assigned = owned & {PIN_CNT{crossbar_on}};

    // per-pin drive, pullup and receiver
    for (int p = 0; p < PIN_CNT; p++) begin
      logic val;
      logic drv;
      logic od;
      logic dig;
      val = 1'b0;
      drv = 1'b0;
      od  = 1'b0;
      dig = q.input_mode_select[p];
      if (owned[p]) begin
        val = periph_out_i[pin_owner[p]];
        drv = periph_oe_i[pin_owner[p]];
        od  = ~q.output_mode_select[p]
              | (pin_owner[p] == SIG_W'(SIG_SMBUS_DATA))
              | (pin_owner[p] == SIG_W'(SIG_SMBUS_CLOCK));
      end else begin
        val = q.port_latch[p];
        drv = 1'b1;
        od  = ~q.output_mode_select[p];
      end
      drv = drv & crossbar_on & dig;
      d.pin_oe[p]     = drv & (od ? ~val : 1'b1);
      d.pin_out[p]    = od ? 1'b0 : val;
      d.pin_pullup[p] = ~q.route_second[F1_WPUD] & od & dig
                        & ~(drv & ~val);
      d.pin_rx_en[p]  = dig;
    end

    // peripheral inputs only while routed
    for (int s = 0; s < SIG_CNT; s++) begin
      d.periph_in[s] = sig_on[s] & crossbar_on
                       & q.sync_second[sig_pin[s]]
                       & q.input_mode_select[sig_pin[s]];
    end

    // read mux, unmapped reads zero
    rd = '0;
    case (wb_adr_i)
      ADR_ROUTE_FIRST:  rd[7:0]  = q.route_first;
      ADR_ROUTE_SECOND: rd[7:0]  = q.route_second;
      ADR_ROUTE_THIRD:  rd[1:0]  = q.route_third;
      ADR_PIN_SKIP:     rd[23:0] = q.pin_skip_mask;
      ADR_INPUT_MODE:   rd[23:0] = q.input_mode_select;
      ADR_OUTPUT_MODE:  rd[23:0] = q.output_mode_select;
      ADR_PORT_LATCH:   rd[23:0] = q.port_latch;
      ADR_PIN_LEVEL:    rd[23:0] = q.sync_second & q.input_mode_select;
      ADR_SPI_CONFIG:   rd[0]    = q.spi_four_wire;
      ADR_ASSIGNED:     rd[23:0] = q.assigned;
      default:          rd       = '0;
    endcase

    // one-cycle ack, write lands on the edge that ends it
    d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
    if (d.ack) begin
      d.rdata = rd;
    end
    wm     = merge(rd, wb_dat_i, wb_sel_i); // current value with written lanes
    wr_now = wb_cyc_i & wb_stb_i & q.ack & wb_we_i;
    if (wr_now) begin
      case (wb_adr_i)
        ADR_ROUTE_FIRST:  d.route_first        = wm[7:0];
        ADR_ROUTE_SECOND: d.route_second       = wm[7:0];
        ADR_ROUTE_THIRD:  d.route_third        = wm[1:0];
        ADR_PIN_SKIP:     d.pin_skip_mask      = wm[23:0];
        ADR_INPUT_MODE:   d.input_mode_select  = wm[23:0];
        ADR_OUTPUT_MODE:  d.output_mode_select = wm[23:0];
        ADR_PORT_LATCH:   d.port_latch         = wm[23:0];
        ADR_SPI_CONFIG:   d.spi_four_wire      = wm[0];
        default:          d.spi_four_wire      = q.spi_four_wire;
      endcase
    end
  end

  // state register, frozen while ce_i is low unless rst_i is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q                    <= '0;
      q.input_mode_select  <= RST_INPUT_MODE;
      q.output_mode_select <= RST_OUTPUT_MODE;
      q.port_latch         <= RST_PORT_LATCH;
      q.pin_rx_en          <= RST_INPUT_MODE;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign wb_dat_o     = q.rdata;
  assign wb_ack_o     = q.ack;
  assign pin_out_o    = q.pin_out;
  assign pin_oe_o     = q.pin_oe;
  assign pin_pullup_o = q.pin_pullup;
  assign pin_rx_en_o  = q.pin_rx_en;
  assign periph_in_o  = q.periph_in;
endmodule
`default_nettype wire

// File: port_crossbar_chk.sv
// Purpose: port-level checks on the crossbar
// Assumes: ack one cycle after a taken request
// Notes:   pin outputs are registered, so relations hold per cycle
`timescale 1ns/10ps
`default_nettype none
module port_crossbar_chk #(
  parameter int PIN_COUNT = crossbar_pkg::PIN_CNT
) (
  input wire logic                             clk_i,
  input wire logic                             rst_i,
  input wire logic                             ce_i,
  input wire logic                             wb_cyc_i,
  input wire logic                             wb_stb_i,
  input wire logic                             wb_ack_o,
  input wire logic [crossbar_pkg::PIN_CNT-1:0] pin_in_i,
  input wire logic [crossbar_pkg::PIN_CNT-1:0] pin_out_o,
  input wire logic [crossbar_pkg::PIN_CNT-1:0] pin_oe_o,
  input wire logic [crossbar_pkg::PIN_CNT-1:0] pin_pullup_o,
  input wire logic [crossbar_pkg::PIN_CNT-1:0] pin_rx_en_o,
  input wire logic [crossbar_pkg::SIG_CNT-1:0] periph_in_o
);
  import crossbar_pkg::*;
  // bus handshake
  ack_latency_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o ##1 ce_i |-> wb_ack_o) else $error("ack late");
  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  // state right after reset
  reset_state_a: assert property (@(posedge clk_i)
    rst_i && ce_i |=> pin_oe_o == '0 && &pin_rx_en_o && periph_in_o == '0) else $error("bad reset state");
  // pullup and driver relations
  pullup_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_oe_o & ~pin_out_o & pin_pullup_o) == '0) else $error("pullup on low drive");
  push_pull_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_oe_o & pin_out_o & pin_pullup_o) == '0) else $error("pullup on push-pull high");
  analog_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (~pin_rx_en_o & (pin_oe_o | pin_pullup_o)) == '0) else $error("analog pin active");
  // fixed receive pin of the first uart
  uart0_rx_a: assert property (@(posedge clk_i) disable iff (rst_i)
    periph_in_o[SIG_UART0_RECEIVE] |-> $past(pin_in_i[UART0_RX_PIN], 3)) else $error("uart0 rx pin");
endmodule
`default_nettype wire

// File: priority_crossbar_port_setup_tb_top.sv
// Purpose: self-checking bench for the crossbar
// Assumes: ack one cycle after request, pins settle in four cycles
// Notes:   routing cases are rows; modes and reset by hand
`timescale 1ns/10ps
`default_nettype none
module priority_crossbar_port_setup_tb_top;
  import crossbar_pkg::*;
  typedef struct packed {
    logic [7:0]  rf;
    logic [7:0]  rs;
    logic [7:0]  rt;
    logic [23:0] skip;
    logic        spi4;
    logic [23:0] taken;
  } row_t;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0]  wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
  logic [23:0] pin_in_i, pin_out_o, pin_oe_o, pin_pullup_o, pin_rx_en_o, ext_en = '0, ext_lvl = '0;
  logic [22:0] periph_out_i = '0, periph_oe_i = '1, periph_in_o;
  int          miscompares = 0, n_checks = 0, cycles = 0;
  row_t        rows[8];
  port_crossbar dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pin_pullup_o(pin_pullup_o), .pin_rx_en_o(pin_rx_en_o), .periph_out_i(periph_out_i),
    .periph_oe_i(periph_oe_i), .periph_in_o(periph_in_o));
  pad_model pads (.clk_i(clk_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .pin_pullup_i(pin_pullup_o),
    .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .pad_o(pin_in_i));
  // clock and hang guard
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // one classic cycle, entered just after a rising edge
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o;
    if (n >= 40) miscompares++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    wb_xfer(1'b1, a, {8'h00, d});
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_i);
  endtask
  // register defaults, an unmapped read and pin state
  task automatic check_reset_state();
    logic [7:0]  ra[8] = '{ADR_ROUTE_FIRST, ADR_ROUTE_SECOND, ADR_ROUTE_THIRD, ADR_PIN_SKIP,
                           ADR_INPUT_MODE, ADR_OUTPUT_MODE, ADR_PORT_LATCH, 8'h3c};
    logic [23:0] rv[8] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'hffffff, 24'h0, 24'hffffff, 24'h0};
    chk_pin("rx_en_rst", 24'hffffff, pin_rx_en_o);
    chk_pin("oe_rst", 24'h0, pin_oe_o);
    for (int i = 0; i < 8; i++) begin
      wb_xfer(1'b0, ra[i], 32'h0);
      chk_reg("reg_rst", {8'h00, rv[i]}, rd);
    end
  endtask
  initial begin
    rows[0] = '{8'h01, 8'h40, 8'h00, 24'h000000, 1'b0, 24'h000030};
    rows[1] = '{8'h02, 8'h40, 8'h00, 24'h000000, 1'b0, 24'h000007};
    rows[2] = '{8'h07, 8'h40, 8'h00, 24'h000000, 1'b0, 24'h00007f};
    rows[3] = '{8'h02, 8'h40, 8'h00, 24'h000003, 1'b0, 24'h00001c};
    rows[4] = '{8'h00, 8'h7d, 8'h00, 24'h0000ff, 1'b0, 24'h00ff00};
    rows[5] = '{8'h02, 8'h40, 8'h00, 24'h000000, 1'b1, 24'h00000f};
    rows[6] = '{8'h00, 8'h40, 8'h01, 24'hfffffe, 1'b0, 24'h000000};
    rows[7] = '{8'h07, 8'h00, 8'h00, 24'h000000, 1'b0, 24'h000000};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check_reset_state();
    wr(ADR_INPUT_MODE, 24'hffffff);
    wr(ADR_OUTPUT_MODE, 24'hffffff);
    // routing rows, enable written last
    for (int i = 0; i < 8; i++) begin
      wr(ADR_PIN_SKIP, rows[i].skip);
      wr(ADR_SPI_CONFIG, {23'h0, rows[i].spi4});
      wr(ADR_ROUTE_FIRST, {16'h0, rows[i].rf});
      wr(ADR_ROUTE_THIRD, {16'h0, rows[i].rt});
      wr(ADR_ROUTE_SECOND, {16'h0, rows[i].rs});
      settle();
      chk_pin("oe_off", 24'h0, pin_oe_o & {24{~rows[i].rs[6]}});
      chk_pin("drive", {24{rows[i].rs[6]}} & ~rows[i].taken, pin_out_o & pin_oe_o);
    end
    // smbus pins stay open-drain while push-pull is set
    wr(ADR_ROUTE_FIRST, 24'h04);
    wr(ADR_ROUTE_SECOND, 24'h40);
    periph_out_i <= '1;
    settle();
    chk_pin("smbus_oe", 24'h000004, pin_oe_o & 24'h000007);
    periph_out_i <= '0;
    // uart0 receive follows pad 5
    periph_oe_i[SIG_UART0_RECEIVE] <= 1'b0;
    ext_en[5] <= 1'b1;
    ext_lvl[5] <= 1'b1;
    wr(ADR_ROUTE_FIRST, 24'h01);
    repeat (7) @(posedge clk_i);
    chk_reg("uart0_rx_hi", 32'h1, {31'h0, periph_in_o[SIG_UART0_RECEIVE]});
    ext_lvl[5] <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk_reg("uart0_rx_lo", 32'h0, {31'h0, periph_in_o[SIG_UART0_RECEIVE]});
    ext_en[5] <= 1'b0;
    // analog pin 9, open-drain pins with pullups
    wr(ADR_INPUT_MODE, 24'hfffdff);
    wr(ADR_OUTPUT_MODE, 24'h000000);
    wr(ADR_PIN_SKIP, 24'h000200);
    wr(ADR_ROUTE_FIRST, 24'h00);
    settle();
    chk_pin("rx_en", 24'hfffdff, pin_rx_en_o);
    chk_pin("pullup", 24'hfffdff, pin_pullup_o);
    wr(ADR_PORT_LATCH, 24'hfffff7);
    settle();
    chk_pin("pullup_low", 24'hfffdf7, pin_pullup_o);
    chk_pin("od_drive", 24'h000008, pin_oe_o);
    wr(ADR_ROUTE_SECOND, 24'hc0);
    settle();
    chk_pin("pullup_off", 24'h0, pin_pullup_o);
    // reset in mid-run
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check_reset_state();
    give_verdict();
  end
endmodule
bind port_crossbar port_crossbar_chk #(.PIN_COUNT(PIN_COUNT)) chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
  .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o), .pin_rx_en_o(pin_rx_en_o), .periph_in_o(periph_in_o));
`default_nettype wire
